/* include/kww_pkg.sv */
// package: register map, field layout and constants of the keyed window watchdog
package kww_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL  = 8'h00;
  localparam logic [7:0] OFF_TIMEOUT  = 8'h04;
  localparam logic [7:0] OFF_WINDOW   = 8'h08;
  localparam logic [7:0] OFF_SERVICE  = 8'h0C;
  localparam logic [7:0] OFF_COUNT    = 8'h10;
  localparam logic [7:0] OFF_KEY      = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  localparam logic [7:0] OFF_MASK     = 8'h1C;
  // control field positions
  localparam int CTL_ENABLE    = 0;
  localparam int CTL_HARD_LOCK = 1;
  localparam int CTL_DBG_HALT  = 2;
  localparam int CTL_IRQ_FIRST = 3;
  localparam int CTL_WINDOWED  = 4;
  localparam int CTL_KEYED     = 5;
  localparam int CTL_WIDTH     = 6;
  // status field positions
  localparam int ST_EXPIRY  = 0;
  localparam int ST_FAULT   = 1;
  localparam int ST_BADSVC  = 2;
  localparam int ST_WIDTH   = 3;
  // reset values and fixed keys
  localparam logic [CTL_WIDTH-1:0] CONTROL_RESET = 6'h00;
  localparam logic [31:0] TIMEOUT_RESET = 32'h0000_FFFF;
  localparam logic [31:0] WINDOW_RESET  = 32'h0000_0000;
  localparam logic [15:0] KEY_RESET     = 16'h0000;
  localparam logic [15:0] FIXED_KEY_FIRST  = 16'hA602;
  localparam logic [15:0] FIXED_KEY_SECOND = 16'hB480;
  // key successor arithmetic
  localparam logic [15:0] KEY_ADD = 16'h0003;
  localparam logic [15:0] KEY_MUL = 16'h0011;

  // control fields as a carrier
  typedef struct packed {
    logic keyed;
    logic windowed;
    logic irq_first;
    logic dbg_halt;
    logic hard_lock;
    logic enable;
  } kww_ctrl_t;

  // service sequence state
  typedef enum logic [1:0] {
    KWW_IDLE    = 2'b00,
    KWW_GOT_ONE = 2'b01
  } kww_svc_t;
endpackage

/* rtl/kww_watchdog.sv */
// keyed window watchdog with classic wishbone register slave
// Overview of operation
// R1: on expiry fault now or interrupt plus reload
// R2: second expiry without service raises fault request
// R3: fixed keys first then second reload counter
// R4: keyed mode accepts only matching hardware key
// R5: next key is 17 times key plus 3; the code computes 17 times (key plus 3)
// R6: enable bit, hard lock blocks configuration writes
// R7: 32-bit timeout period loads the counter
// R8: windowed mode rejects service outside window
// R9: windowed and keyed modes selectable independently
// R10: debug halt bit stops counting in debug
// R11: count down per cycle, zero is expiry
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module kww_watchdog #(
  parameter logic [31:0] TIMEOUT_DEFAULT = kww_pkg::TIMEOUT_RESET
) (
  // clock, reset, enable
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic        clk_en_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // device state
  input  wire logic        debug_mode_in,
  // outputs to system
  output logic             fault_request_out,
  output logic             irq_out
);

  // register state
  kww_pkg::kww_ctrl_t            ctrl_reg;
  logic [31:0]                   timeout_reg;
  logic [31:0]                   window_reg;
  logic [31:0]                   count_reg;
  logic [15:0]                   key_reg;
  logic [kww_pkg::ST_WIDTH-1:0]  status_reg;
  logic [kww_pkg::ST_WIDTH-1:0]  mask_reg;
  logic                          pending_reg;
  logic                          fault_reg;
  kww_pkg::kww_svc_t             svc_reg;

  // decoded strobes
  logic        access;
  logic        wr;
  logic [31:0] wmask;
  logic        svc_wr;
  logic        in_window;
  logic        svc_ok;
  logic        svc_bad;
  logic        expiry;
  logic        running;
  logic        cfg_open;
  logic        mapped;

  // byte enable mask, used for the timeout and window register writes
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // next pseudo-random key, modulo 2^16 by truncation
  function automatic logic [15:0] key_next(input logic [15:0] k);
    logic [31:0] prod;
    prod = 32'(kww_pkg::KEY_MUL) * 32'(k + kww_pkg::KEY_ADD);
    key_next = prod[15:0]; // R5
  endfunction

  // bus strobes: single-cycle answer, ack drops the cycle after
  assign access   = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr       = access && wb_we_in && clk_en_in;
  assign wmask    = sel_mask(wb_sel_in);
  assign cfg_open = !ctrl_reg.hard_lock; // R6
  assign mapped   = (wb_adr_in <= kww_pkg::OFF_MASK) && (wb_adr_in[1:0] == 2'b00);

  // counting and service qualification
  assign running   = ctrl_reg.enable && !(ctrl_reg.dbg_halt && debug_mode_in); // R10
  assign expiry    = running && (count_reg == 32'h0000_0000); // R11
  assign svc_wr    = wr && (wb_adr_in == kww_pkg::OFF_SERVICE) && ctrl_reg.enable;
  // window open once the count has fallen to the window value
  assign in_window = !ctrl_reg.windowed || (count_reg <= window_reg); // R8 R9

  // service decision per mode
  always_comb begin
    svc_ok  = 1'b0;
    svc_bad = 1'b0;
    if (svc_wr) begin
      if (!in_window) begin
        svc_bad = 1'b1; // R8
      end else if (ctrl_reg.keyed) begin
        svc_ok  = (wb_dat_in[15:0] == key_reg); // R4
        svc_bad = !svc_ok;
      end else begin
        // first key arms, second key completes the pair
        svc_ok  = (svc_reg == kww_pkg::KWW_GOT_ONE) &&
                  (wb_dat_in[15:0] == kww_pkg::FIXED_KEY_SECOND); // R3
        svc_bad = !svc_ok && (wb_dat_in[15:0] != kww_pkg::FIXED_KEY_FIRST);
      end
    end
  end

  // wishbone acknowledge
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
    end else if (clk_en_in) begin
      wb_ack_out <= access;
    end
  end

  // read data, unmapped addresses read zero
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (clk_en_in && access && !mapped) begin
      // holes and misaligned addresses never leak a register value
      wb_dat_out <= 32'h0000_0000;
    end else if (clk_en_in && access) begin
      unique case (wb_adr_in)
        kww_pkg::OFF_CONTROL: wb_dat_out <= 32'(ctrl_reg);
        kww_pkg::OFF_TIMEOUT: wb_dat_out <= timeout_reg;
        kww_pkg::OFF_WINDOW:  wb_dat_out <= window_reg;
        kww_pkg::OFF_COUNT:   wb_dat_out <= count_reg;
        kww_pkg::OFF_KEY:     wb_dat_out <= 32'(key_reg);
        kww_pkg::OFF_STATUS:  wb_dat_out <= 32'(status_reg);
        kww_pkg::OFF_MASK:    wb_dat_out <= 32'(mask_reg);
        default:              wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  // control register; hard lock only clears by reset
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      ctrl_reg <= kww_pkg::CONTROL_RESET;
    end else if (wr && wb_sel_in[0] && cfg_open &&
                 wb_adr_in == kww_pkg::OFF_CONTROL) begin
      ctrl_reg <= wb_dat_in[kww_pkg::CTL_WIDTH-1:0]; // R6 R9
    end
  end

  // timeout and window registers, frozen by hard lock
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      timeout_reg <= TIMEOUT_DEFAULT;
      window_reg  <= kww_pkg::WINDOW_RESET;
    end else if (wr && cfg_open) begin
      if (wb_adr_in == kww_pkg::OFF_TIMEOUT) begin
        timeout_reg <= (timeout_reg & ~wmask) | (wb_dat_in & wmask); // R7
      end
      if (wb_adr_in == kww_pkg::OFF_WINDOW) begin
        window_reg <= (window_reg & ~wmask) | (wb_dat_in & wmask);
      end
    end
  end

  // interrupt mask, writable always since it gates only the irq
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      mask_reg <= '0;
    end else if (wr && wb_sel_in[0] && wb_adr_in == kww_pkg::OFF_MASK) begin
      mask_reg <= wb_dat_in[kww_pkg::ST_WIDTH-1:0];
    end
  end

  // down-counter: reload every cycle while disabled, on service, or on interrupt expiry
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      count_reg <= TIMEOUT_DEFAULT;
    end else if (clk_en_in) begin
      if (!ctrl_reg.enable || svc_ok) begin
        count_reg <= timeout_reg; // R3 R4 R7
      end else if (expiry) begin
        // fault path holds at zero; interrupt path reloads
        if (ctrl_reg.irq_first && !pending_reg) begin
          count_reg <= timeout_reg; // R1
        end
      end else if (running) begin
        count_reg <= count_reg - 32'h0000_0001; // R11
      end
    end
  end

  // fixed key sequence tracker; bad writes leave the counter alone
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      svc_reg <= kww_pkg::KWW_IDLE;
    end else if (svc_wr && !ctrl_reg.keyed) begin
      if (in_window && wb_dat_in[15:0] == kww_pkg::FIXED_KEY_FIRST) begin
        svc_reg <= kww_pkg::KWW_GOT_ONE; // R3
      end else begin
        svc_reg <= kww_pkg::KWW_IDLE;
      end
    end
  end

  // service key regenerates after each good keyed service
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      key_reg <= kww_pkg::KEY_RESET;
    end else if (svc_ok && ctrl_reg.keyed) begin
      key_reg <= key_next(key_reg); // R4 R5
    end
  end

  // first interrupt expiry pending until serviced or disabled
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pending_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (svc_ok || !ctrl_reg.enable) begin
        pending_reg <= 1'b0;
      end else if (expiry && ctrl_reg.irq_first) begin
        pending_reg <= 1'b1; // R2
      end
    end
  end

  // fault request latches; only reset clears it, a safety choice
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      fault_reg <= 1'b0;
    end else if (clk_en_in && expiry && (!ctrl_reg.irq_first || pending_reg)) begin
      fault_reg <= 1'b1; // R1 R2
    end
  end

  // sticky status: set beats the write-one clear
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      status_reg <= '0;
    end else if (clk_en_in) begin
      status_reg <= (status_reg &
                     ~((wr && wb_sel_in[0] && wb_adr_in == kww_pkg::OFF_STATUS) ?
                       wb_dat_in[kww_pkg::ST_WIDTH-1:0] : '0)) |
                    {svc_bad,
                     expiry && (!ctrl_reg.irq_first || pending_reg),
                     expiry};
    end
  end

  // outputs
  assign fault_request_out = fault_reg;
  assign irq_out           = |(status_reg & mask_reg);

endmodule

/* sim/kww_watchdog_props.sv */
// checker: bus handshake and output relations of the keyed window watchdog
`timescale 1ns/1ps
module kww_props #(
  parameter logic [31:0] TIMEOUT_DEFAULT = kww_pkg::TIMEOUT_RESET
) (
  // clock, reset, enable
  input wire logic        clock_in,
  input wire logic        nrst_in,
  input wire logic        clk_en_in,
  // bus
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  // device side
  input wire logic        debug_mode_in,
  input wire logic        fault_request_out,
  input wire logic        irq_out
);
  wire logic req = wb_cyc_in && wb_stb_in && !wb_ack_out && clk_en_in;
  logic      armed_reg;
  // set by any write; an untouched watchdog stays disabled
  always_ff @(posedge clock_in) begin
    if (!nrst_in) armed_reg <= 1'b0;
    else if (wb_cyc_in && wb_stb_in && wb_we_in) armed_reg <= 1'b1;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  a_ack_next: assert property (req |=> wb_ack_out) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_out && clk_en_in |=> !wb_ack_out) else $error("ack long");
  a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  a_ack_idle: assert property (clk_en_in && !wb_cyc_in |=> !wb_ack_out) else $error("stray ack");
  a_zero_read: assert property (req && !wb_we_in && (wb_adr_in == 8'h0C || wb_adr_in > 8'h1C)
    |=> wb_dat_out == 32'h0) else $error("nonzero read");
  a_fault_sticky: assert property (fault_request_out |=> fault_request_out) else $error("fault drop");
  a_quiet_unarmed: assert property (!armed_reg |-> !fault_request_out && !irq_out)
    else $error("output while disabled");
  a_fault_late: assert property ($rose(fault_request_out) |-> $past(armed_reg, 2))
    else $error("fault too early");
  c_fault: cover property ($rose(fault_request_out));
  c_irq: cover property ($rose(irq_out));
  c_read: cover property (wb_ack_out && !wb_we_in);
endmodule
bind kww_watchdog kww_props #(.TIMEOUT_DEFAULT(TIMEOUT_DEFAULT)) u_props (
  .clock_in(clock_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .debug_mode_in(debug_mode_in), .fault_request_out(fault_request_out), .irq_out(irq_out));

/* sim/kww_watchdog_bench.sv */
// bench: randomized register tests of the keyed window watchdog
`timescale 1ns/1ps
module kww_watchdog_bench;
  logic        clock_in = 1'b0, nrst_in = 1'b0, clk_en_in = 1'b1, debug_mode_in = 1'b0;
  logic        wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [7:0]  wb_adr_in = 8'h00;
  logic [3:0]  wb_sel_in = 4'hF;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd, t;
  logic        wb_ack_out, fault_request_out, irq_out;
  logic [15:0] k;
  int          bad_count = 0, cmp_count = 0, ticks = 0, n;
  // half period of 12.5 ns gives 40 MHz
  always #12.5 clock_in = ~clock_in;
  kww_watchdog #(.TIMEOUT_DEFAULT(32'h20)) dut_u (.clock_in(clock_in), .nrst_in(nrst_in),
    .clk_en_in(clk_en_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .debug_mode_in(debug_mode_in),
    .fault_request_out(fault_request_out), .irq_out(irq_out));
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, we, a, d};
    @(posedge clock_in);
    while (wb_ack_out !== 1'b1) @(posedge clock_in);
    rd = wb_dat_out;
    {wb_cyc_in, wb_stb_in} <= 2'b00;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic rst();
    nrst_in <= 1'b0;
    repeat (12) @(posedge clock_in);
    nrst_in <= 1'b1;
  endtask
  // next service key, wraps at 16 bits
  function automatic logic [15:0] nk(input logic [15:0] v);
    return 16'h0011 * (v + 16'h0003);
  endfunction
  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge clock_in) begin
    ticks++;
    if (ticks == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h5A73AB5B));
    rst();
    rc(8'h04, 32'h20);
    rc(8'h00, 32'h0);
    rc(8'h24, 32'h0);
    wb(1'b1, 8'h04, 32'h100);
    wb(1'b1, 8'h08, 32'h40);
    wb(1'b1, 8'h00, 32'h21);
    k = 16'h0000;
    wb(1'b1, 8'h0C, $urandom | 32'h1);
    rc(8'h14, 32'h0);
    wb(1'b0, 8'h18, 32'h0);
    chk(32'(rd[2]), 32'h1);
    repeat (4) begin
      wb(1'b1, 8'h0C, {16'h0000, k});
      k = nk(k);
      rc(8'h14, {16'h0000, k});
    end
    // windowed and keyed together: early write refused, late one taken
    wb(1'b1, 8'h00, 32'h31);
    wb(1'b1, 8'h0C, {16'h0000, k});
    rc(8'h14, {16'h0000, k});
    repeat (200) @(posedge clock_in);
    wb(1'b1, 8'h0C, {16'h0000, k});
    k = nk(k);
    rc(8'h14, {16'h0000, k});
    wb(1'b1, 8'h00, 32'h05);
    debug_mode_in <= 1'b1;
    wb(1'b0, 8'h10, 32'h0);
    rc(8'h10, rd);
    wb(1'b1, 8'h00, 32'h01);
    wb(1'b0, 8'h10, 32'h0);
    t = rd;
    // freeze the clock enable for five edges; the count must not move then
    clk_en_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    clk_en_in <= 1'b1;
    wb(1'b0, 8'h10, 32'h0);
    chk(32'(rd < t), 32'h1);
    chk(rd, t - 32'h3);
    debug_mode_in <= 1'b0;
    t = 32'h10 + ($urandom & 32'hF);
    wb(1'b1, 8'h04, t);
    wb(1'b1, 8'h1C, 32'h1);
    wb(1'b1, 8'h00, 32'h09);
    for (n = 0; n < 400 && irq_out !== 1'b1; n++) @(posedge clock_in);
    chk(32'(irq_out), 32'h1);
    chk(32'(fault_request_out), 32'h0);
    wb(1'b1, 8'h0C, 32'hA602);
    wb(1'b1, 8'h0C, 32'hB480);
    wb(1'b0, 8'h10, 32'h0);
    chk(32'(rd > t - 32'h5), 32'h1);
    wb(1'b1, 8'h1C, 32'h0);
    chk(32'(irq_out), 32'h0);
    wb(1'b1, 8'h1C, 32'h1);
    chk(32'(irq_out), 32'h1);
    wb(1'b1, 8'h18, 32'h1);
    chk(32'(irq_out), 32'h0);
    for (n = 0; n < 200 && fault_request_out !== 1'b1; n++) @(posedge clock_in);
    chk(32'(fault_request_out), 32'h1);
    rst();
    // byte 0 only: upper bytes of the timeout keep their reset value
    wb_sel_in <= 4'h1;
    wb(1'b1, 8'h04, 32'hFFFF_FF10);
    wb_sel_in <= 4'hF;
    rc(8'h04, 32'h10);
    wb(1'b1, 8'h00, 32'h01);
    for (n = 0; n < 60 && fault_request_out !== 1'b1; n++) @(posedge clock_in);
    chk(32'(n > 8 && n < 24), 32'h1);
    chk(32'(irq_out), 32'h0);
    rc(8'h18, 32'h3);
    rst();
    wb(1'b1, 8'h00, 32'h02);
    wb(1'b1, 8'h04, 32'h55);
    rc(8'h04, 32'h20);
    wb(1'b1, 8'h00, 32'h01);
    rc(8'h00, 32'h02);
    give_verdict();
  end
endmodule
